// >>> verilog/gpio_port_bank_defines.svh
`ifndef GPIO_PORT_BANK_DEFINES_SVH
`define GPIO_PORT_BANK_DEFINES_SVH

// register offsets within one port window, and the offset of the bank control register
`define PORT_STRIDE         8'h10
`define OFS_PIN_DIRECTION   2'h0
`define OFS_OUTPUT_LATCH    2'h1
`define OFS_PIN_LEVEL       2'h2
`define OFS_OPEN_DRAIN      2'h3
`define OFS_BANK_CONTROL    8'h70

// bank control register fields
`define CTRL_SERIAL_OWN_BIT 0

// reset values
`define DIRECTION_RESET     16'hFFFF
`define LATCH_RESET         16'h0000
`define OPEN_DRAIN_RESET    16'h0000

// implemented bit positions of each port, A to G
`define IMPL_MASK_A         16'hFFFF
`define IMPL_MASK_B         16'hFFFF
`define IMPL_MASK_C         16'hFFFF
`define IMPL_MASK_D         16'hFFFF
`define IMPL_MASK_E         16'hFFFF
`define IMPL_MASK_F         16'hFFFF
`define IMPL_MASK_G         16'hFFFF

// indicator led pins on the sixth port
`define LED_PORT            3'd5
`define LED_BIT_A           4'd0
`define LED_BIT_B           4'd1

// pins taken over by the two-wire serial function
`define SERIAL_PORT         3'd6
`define SERIAL_BIT_CLK      4'd2
`define SERIAL_BIT_DAT      4'd3

// AXI responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// >>> verilog/gpio_port_bank_pkg.sv
package gpio_port_bank_pkg;

    typedef enum logic [1:0] {
        rd_idle,
        rd_fetch,
        rd_answer
    } rd_state_type;

    typedef logic [15:0] port_word_type;

endpackage

// >>> verilog/gpio_port_if.sv
`timescale 1ns/1ps
`default_nettype none

interface gpio_port_if;
    import gpio_port_bank_pkg::*;

    logic          wr_direction;
    logic          wr_latch;
    logic          wr_open_drain;
    port_word_type wdata;
    port_word_type wmask;
    port_word_type direction;
    port_word_type latch;
    port_word_type open_drain;

    modport regs (
        input  wr_direction,
        input  wr_latch,
        input  wr_open_drain,
        input  wdata,
        input  wmask,
        output direction,
        output latch,
        output open_drain
    );

    modport ctl (
        output wr_direction,
        output wr_latch,
        output wr_open_drain,
        output wdata,
        output wmask,
        input  direction,
        input  latch,
        input  open_drain
    );

endinterface

`default_nettype wire

// >>> verilog/gpio_port_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_bank_defines.svh"

module gpio_port_regs #(
    parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    gpio_port_if.regs   port
);
    import gpio_port_bank_pkg::*;

    port_word_type direction_q;
    port_word_type direction_d;
    port_word_type latch_q;
    port_word_type latch_d;
    port_word_type open_drain_q;
    port_word_type open_drain_d;
    port_word_type keep;

    // absent bits never change, so they keep their reset value
    assign keep         = port.wmask & IMPL_MASK;
    assign direction_d  = (direction_q & ~keep) | (port.wdata & keep);
    assign latch_d      = (latch_q & ~keep) | (port.wdata & keep);
    assign open_drain_d = (open_drain_q & ~keep) | (port.wdata & keep);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            direction_q  <= `DIRECTION_RESET;
            latch_q      <= `LATCH_RESET;
            open_drain_q <= `OPEN_DRAIN_RESET;
        end else begin
            if (port.wr_direction) begin
                direction_q <= direction_d;
            end
            if (port.wr_latch) begin
                latch_q <= latch_d;
            end
            if (port.wr_open_drain) begin
                open_drain_q <= open_drain_d;
            end
        end
    end

    assign port.direction  = direction_q & IMPL_MASK;
    assign port.latch      = latch_q & IMPL_MASK;
    assign port.open_drain = open_drain_q & IMPL_MASK;

endmodule

`default_nettype wire

// >>> verilog/gpio_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_cell (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic present,
    input  wire logic direction,
    input  wire logic latch,
    input  wire logic open_drain,
    input  wire logic alt_sel,
    input  wire logic alt_out,
    input  wire logic alt_oe,
    input  wire logic pad_in,
    output logic      pad_out,
    output logic      pad_oe,
    output logic      level
);

    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic level_q;
    logic pad_out_q;
    logic pad_oe_q;
    logic gpio_out;
    logic gpio_oe;

    // open drain drives low only; a latch of 1 releases the pin
    assign gpio_out = open_drain ? 1'b0 : latch;
    assign gpio_oe  = ~direction & (open_drain ? ~latch : 1'b1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q   <= 1'b0;
            sync2_q   <= 1'b0;
            sync3_q   <= 1'b0;
            level_q   <= 1'b0;
            pad_out_q <= 1'b0;
            pad_oe_q  <= 1'b0;
        end else begin
            sync1_q   <= pad_in;
            sync2_q   <= sync1_q;
            sync3_q   <= sync2_q;
            // a change counts only once the last two stages agree
            if (sync2_q == sync3_q) begin
                level_q <= sync3_q;
            end
            pad_out_q <= present & (alt_sel ? alt_out : gpio_out);
            pad_oe_q  <= present & (alt_sel ? alt_oe : gpio_oe);
        end
    end

    assign pad_out = pad_out_q;
    assign pad_oe  = pad_oe_q;
    assign level   = present & level_q;

endmodule

`default_nettype wire

// >>> verilog/gpio_port_bank.sv
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_bank_defines.svh"

module gpio_port_bank (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    input  wire logic [111:0] pad_in,
    output logic [111:0]      pad_out,
    output logic [111:0]      pad_oe,
    input  wire logic [1:0]   serial_out,
    input  wire logic [1:0]   serial_oe,
    output logic              indicator_led_a,
    output logic              indicator_led_b
);
    import gpio_port_bank_pkg::*;

    localparam int NPORTS = 7;
    localparam logic [15:0] IMPL_MASKS [NPORTS] = '{
        `IMPL_MASK_A, `IMPL_MASK_B, `IMPL_MASK_C, `IMPL_MASK_D,
        `IMPL_MASK_E, `IMPL_MASK_F, `IMPL_MASK_G
    };

    // write channel state
    logic         awready_q;
    logic         wready_q;
    logic         aw_have_q;
    logic         w_have_q;
    logic [7:0]   waddr_q;
    logic [31:0]  wdata_q;
    logic [3:0]   wstrb_q;
    logic         bvalid_q;
    logic [1:0]   bresp_q;

    // read channel state
    rd_state_type rd_state_q;
    logic         arready_q;
    logic [7:0]   raddr_q;
    logic         rvalid_q;
    logic [31:0]  rdata_q;
    logic [1:0]   rresp_q;

    logic         serial_own_q;
    logic         led_a_q;
    logic         led_b_q;

    // decode wires
    logic         aw_fire;
    logic         w_fire;
    logic         wr_go;
    logic [2:0]   wr_port;
    logic [1:0]   wr_reg;
    logic         wr_in_port;
    logic         wr_ctrl;
    logic         wr_ok;
    logic [15:0]  wr_mask;
    logic         ar_fire;
    logic [2:0]   rd_port;
    logic [1:0]   rd_reg;
    logic         rd_in_port;
    logic         rd_ctrl;
    logic         rd_ok;
    logic [15:0]  rd_sel;
    logic [31:0]  rd_word;

    logic         wr_lo_byte;
    logic         wr_hi_byte;
    logic         ctrl_wr;
    logic [1:0]   wr_resp;
    logic         b_done;
    logic [1:0]   rd_resp;
    logic         r_done;
    logic         rd_is_dir;
    logic         rd_is_lat;
    logic         rd_is_lvl;
    logic         led_a_d;
    logic         led_b_d;

    port_word_type dir_all   [NPORTS];
    port_word_type lat_all   [NPORTS];
    port_word_type odc_all   [NPORTS];
    port_word_type level_all [NPORTS];
    port_word_type level_rd  [NPORTS];

    assign aw_fire    = s_axi_awvalid & awready_q;
    assign w_fire     = s_axi_wvalid & wready_q;
    assign wr_go      = aw_have_q & w_have_q & ~bvalid_q;
    assign wr_port    = waddr_q[6:4];
    assign wr_reg     = waddr_q[3:2];
    assign wr_in_port = (waddr_q[7] == 1'b0) && (wr_port < 3'd7);
    assign wr_ctrl    = (waddr_q[7:2] == 6'(`OFS_BANK_CONTROL >> 2));
    assign wr_ok      = wr_in_port | wr_ctrl;
    assign wr_resp    = wr_ok ? `RESP_OKAY : `RESP_SLVERR;

    // only the two low byte lanes carry register bits
    assign wr_lo_byte = wstrb_q[0];
    assign wr_hi_byte = wstrb_q[1];
    assign wr_mask    = {{8{wr_hi_byte}}, {8{wr_lo_byte}}};
    assign ctrl_wr    = wr_go & wr_ctrl & wr_lo_byte;
    assign b_done     = bvalid_q & s_axi_bready;

    assign ar_fire    = s_axi_arvalid & arready_q;
    assign rd_port    = raddr_q[6:4];
    assign rd_reg     = raddr_q[3:2];
    assign rd_in_port = (raddr_q[7] == 1'b0) && (rd_port < 3'd7);
    assign rd_ctrl    = (raddr_q[7:2] == 6'(`OFS_BANK_CONTROL >> 2));
    assign rd_ok      = rd_in_port | rd_ctrl;
    assign rd_resp    = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    assign r_done     = rvalid_q & s_axi_rready;

    // register chosen within the addressed port
    assign rd_is_dir  = (rd_reg == `OFS_PIN_DIRECTION);
    assign rd_is_lat  = (rd_reg == `OFS_OUTPUT_LATCH);
    assign rd_is_lvl  = (rd_reg == `OFS_PIN_LEVEL);

    // per-port registers and per-pin drivers
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        gpio_port_if pif ();
        logic hit;

        assign hit               = wr_go & wr_in_port & (wr_port == 3'(p));
        assign pif.wr_direction  = hit & (wr_reg == `OFS_PIN_DIRECTION);
        // a write to pin level lands in the output latch
        assign pif.wr_latch      = hit & ((wr_reg == `OFS_OUTPUT_LATCH)
                                          | (wr_reg == `OFS_PIN_LEVEL));
        assign pif.wr_open_drain = hit & (wr_reg == `OFS_OPEN_DRAIN);
        assign pif.wdata         = wdata_q[15:0];
        assign pif.wmask         = wr_mask;

        gpio_port_regs #(
            .IMPL_MASK (IMPL_MASKS[p])
        ) u_regs (
            .aclk    (aclk),
            .aresetn (aresetn),
            .port    (pif)
        );

        assign dir_all[p] = pif.direction;
        assign lat_all[p] = pif.latch;
        assign odc_all[p] = pif.open_drain;

        for (genvar b = 0; b < 16; b++) begin : g_pin
            logic is_led;
            logic is_serial;
            logic alt_sel;
            logic alt_out;
            logic alt_oe;

            // led pins reach no connector, so they never drive a pad
            assign is_led    = (p == `LED_PORT)
                               && ((b == `LED_BIT_A) || (b == `LED_BIT_B));
            assign is_serial = (p == `SERIAL_PORT)
                               && ((b == `SERIAL_BIT_CLK) || (b == `SERIAL_BIT_DAT));
            assign alt_sel   = is_serial & serial_own_q;
            assign alt_out   = (b == `SERIAL_BIT_CLK) ? serial_out[0] : serial_out[1];
            assign alt_oe    = (b == `SERIAL_BIT_CLK) ? serial_oe[0] : serial_oe[1];

            gpio_pin_cell u_pin (
                .aclk       (aclk),
                .aresetn    (aresetn),
                .present    (IMPL_MASKS[p][b] & ~is_led),
                .direction  (dir_all[p][b]),
                .latch      (lat_all[p][b]),
                .open_drain (odc_all[p][b]),
                .alt_sel    (alt_sel),
                .alt_out    (alt_out),
                .alt_oe     (alt_oe),
                .pad_in     (pad_in[p*16+b]),
                .pad_out    (pad_out[p*16+b]),
                .pad_oe     (pad_oe[p*16+b]),
                .level      (level_all[p][b])
            );

            // the led pins read back the level they drive
            if ((p == `LED_PORT) && (b == `LED_BIT_A)) begin : g_led_a
                assign level_rd[p][b] = led_a_q;
            end else if ((p == `LED_PORT) && (b == `LED_BIT_B)) begin : g_led_b
                assign level_rd[p][b] = led_b_q;
            end else begin : g_plain
                assign level_rd[p][b] = level_all[p][b];
            end
        end
    end

    // read data selection
    assign rd_sel = !rd_in_port ? 16'h0000          :
                    rd_is_dir   ? dir_all[rd_port]  :
                    rd_is_lat   ? lat_all[rd_port]  :
                    rd_is_lvl   ? level_rd[rd_port] :
                                  odc_all[rd_port];
    assign rd_word = rd_ctrl ? {31'h0, serial_own_q} : {16'h0000, rd_sel};

    // write address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            waddr_q   <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (aw_fire) begin
                awready_q <= 1'b0;
                aw_have_q <= 1'b1;
                waddr_q   <= s_axi_awaddr;
            end
            if (w_fire) begin
                wready_q <= 1'b0;
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end
            if (b_done) begin
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // write response and bank control
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q     <= 1'b0;
            bresp_q      <= `RESP_OKAY;
            serial_own_q <= 1'b0;
        end else begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_resp;
            end else if (b_done) begin
                bvalid_q <= 1'b0;
            end
            if (ctrl_wr) begin
                serial_own_q <= wdata_q[`CTRL_SERIAL_OWN_BIT];
            end
        end
    end

    // read channel: address taken, data fetched next edge, then answered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q <= rd_idle;
            arready_q  <= 1'b1;
            raddr_q    <= 8'h00;
            rvalid_q   <= 1'b0;
            rdata_q    <= 32'h0000_0000;
            rresp_q    <= `RESP_OKAY;
        end else begin
            case (rd_state_q)
                rd_idle: begin
                    if (ar_fire) begin
                        arready_q  <= 1'b0;
                        raddr_q    <= s_axi_araddr;
                        rd_state_q <= rd_fetch;
                    end
                end
                rd_fetch: begin
                    rvalid_q   <= 1'b1;
                    rdata_q    <= rd_word;
                    rresp_q    <= rd_resp;
                    rd_state_q <= rd_answer;
                end
                rd_answer: begin
                    if (r_done) begin
                        rvalid_q   <= 1'b0;
                        arready_q  <= 1'b1;
                        rd_state_q <= rd_idle;
                    end
                end
                default: begin
                    rd_state_q <= rd_idle;
                end
            endcase
        end
    end

    // leds light on a high output level, only while set as outputs
    assign led_a_d = ~dir_all[`LED_PORT][`LED_BIT_A] & lat_all[`LED_PORT][`LED_BIT_A];
    assign led_b_d = ~dir_all[`LED_PORT][`LED_BIT_B] & lat_all[`LED_PORT][`LED_BIT_B];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_a_q <= 1'b0;
            led_b_q <= 1'b0;
        end else begin
            led_a_q <= led_a_d;
            led_b_q <= led_b_d;
        end
    end

    assign s_axi_awready   = awready_q;
    assign s_axi_wready    = wready_q;
    assign s_axi_bvalid    = bvalid_q;
    assign s_axi_bresp     = bresp_q;
    assign s_axi_arready   = arready_q;
    assign s_axi_rvalid    = rvalid_q;
    assign s_axi_rdata     = rdata_q;
    assign s_axi_rresp     = rresp_q;
    assign indicator_led_a = led_a_q;
    assign indicator_led_b = led_b_q;

endmodule

`default_nettype wire

// >>> bench/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none

// external devices on the pins: they drive every pin that the bank releases
module pin_partner (
    input  wire logic [111:0] pad_out,
    input  wire logic [111:0] pad_oe,
    input  wire logic [111:0] ext_val,
    output logic [111:0]      pad_in
);
    // resolved wire level fed back to the bank
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
endmodule

`default_nettype wire

// >>> bench/gpio_port_bank_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_bank_defines.svh"

module gpio_port_bank_asserts (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         s_axi_awvalid,
    input  wire logic         s_axi_awready,
    input  wire logic         s_axi_wvalid,
    input  wire logic         s_axi_wready,
    input  wire logic [1:0]   s_axi_bresp,
    input  wire logic         s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic         s_axi_arvalid,
    input  wire logic         s_axi_arready,
    input  wire logic [31:0]  s_axi_rdata,
    input  wire logic [1:0]   s_axi_rresp,
    input  wire logic         s_axi_rvalid,
    input  wire logic         s_axi_rready,
    input  wire logic [111:0] pad_oe,
    input  wire logic         indicator_led_a,
    input  wire logic         indicator_led_b
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_pads_idle: assert property (
        $rose(aresetn) |-> pad_oe == 112'h0 && !indicator_led_a && !indicator_led_b)
        else $error("pads or leds active after reset");
    a_write_resp_time: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response latency wrong");
    a_write_ready_low: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_awready && !s_axi_wready) else $error("write ready not lowered");
    a_read_resp_time: assert property (
        s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("read response latency wrong");
    a_read_ready_low: assert property (
        s_axi_arvalid && s_axi_arready |=> !s_axi_arready [*2])
        else $error("arready not lowered");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rdata_width: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0) else $error("upper read bits set");
    a_refused_zero: assert property (
        s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    a_led_pads_off: assert property (
        pad_oe[81:80] == 2'b00) else $error("led pins driven on pads");
endmodule

bind gpio_port_bank gpio_port_bank_asserts gpio_port_bank_asserts_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pad_oe(pad_oe), .indicator_led_a(indicator_led_a), .indicator_led_b(indicator_led_b)
);

`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_bank_defines.svh"

module testbench;
    typedef struct {
        logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [1:0] br;
        logic [7:0] ra; logic [31:0] rd; logic [1:0] rr;
    } row_type;

    logic         aclk, aresetn;
    logic [7:0]   s_axi_awaddr, s_axi_araddr;
    logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0]  s_axi_wdata, s_axi_rdata;
    logic [3:0]   s_axi_wstrb;
    logic [1:0]   s_axi_bresp, s_axi_rresp, serial_out, serial_oe, r;
    logic         s_axi_bvalid, s_axi_bready, s_axi_arready, s_axi_arvalid;
    logic         s_axi_rvalid, s_axi_rready, indicator_led_a, indicator_led_b;
    logic [111:0] pad_in, pad_out, pad_oe, ext_val;
    logic [31:0]  q;
    logic [15:0]  eoe, eout;
    int           n_errors, num_checks, stall;

    row_type rows [7] = '{
        '{8'h04, 32'h0000A5C3, 4'hF, `RESP_OKAY, 8'h04, 32'h0000A5C3, `RESP_OKAY},
        '{8'h08, 32'h00001234, 4'hF, `RESP_OKAY, 8'h04, 32'h00001234, `RESP_OKAY},
        '{8'h00, 32'hFFFF0F0F, 4'hF, `RESP_OKAY, 8'h00, 32'h00000F0F, `RESP_OKAY},
        '{8'h0C, 32'h000000F0, 4'hF, `RESP_OKAY, 8'h0C, 32'h000000F0, `RESP_OKAY},
        '{8'h14, 32'h0000BEEF, 4'h1, `RESP_OKAY, 8'h14, 32'h000000EF, `RESP_OKAY},
        '{8'h80, 32'h12345678, 4'hF, `RESP_SLVERR, 8'h80, 32'h0, `RESP_SLVERR},
        '{8'h64, 32'h0000FFFF, 4'hF, `RESP_OKAY, 8'h64, 32'h0000FFFF, `RESP_OKAY}
    };

    gpio_port_bank gpio_port_bank_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .serial_out(serial_out), .serial_oe(serial_oe),
        .indicator_led_a(indicator_led_a), .indicator_led_b(indicator_led_b)
    );

    pin_partner pin_partner_inst (
        .pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val), .pad_in(pad_in)
    );

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task check(input bit ok, input string m);
        num_checks++;
        if (!ok) begin
            n_errors++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    task stop_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= (stall == 0);
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) break;
            // a stalled master lets the answer wait a few cycles
            if (s_axi_bvalid === 1'b1 && stall > 0) stall--;
            if (stall == 0) s_axi_bready <= 1'b1;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task axi_read(input logic [7:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= (stall == 0);
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
            if (s_axi_rvalid === 1'b1 && stall > 0) stall--;
            if (stall == 0) s_axi_rready <= 1'b1;
        end
        q = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task do_reset(input int n);
        aresetn <= 1'b0;
        repeat (n) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        stop_test();
    end

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
        serial_out <= 2'b00;
        serial_oe  <= 2'b00;
        ext_val    <= 112'h5A5A;
        do_reset(16);
        for (int p = 0; p < 7; p++) begin
            axi_read(8'(p * 16));
            check(q === 32'h0000FFFF, "direction reset value");
            axi_read(8'(p * 16 + 4));
            check(q === 32'h0, "latch reset value");
            axi_read(8'(p * 16 + 12));
            check(q === 32'h0, "open drain reset value");
        end
        foreach (rows[i]) begin
            axi_write(rows[i].a, rows[i].d, rows[i].s);
            check(r === rows[i].br, "write response");
            axi_read(rows[i].ra);
            check(q === rows[i].rd && r === rows[i].rr, "read back");
        end
        // port A now: direction 0F0F, latch 1234, open drain 00F0
        eoe  = ~16'h0F0F & (~16'h00F0 | ~16'h1234);
        eout = ~16'h0F0F & ~16'h00F0 & 16'h1234;
        repeat (8) @(posedge aclk);
        check(pad_oe[15:0] === eoe, "pad enables");
        check((pad_out[15:0] & eoe) === eout, "pad values");
        axi_read(8'h08);
        check(q[15:0] === ((eoe & eout) | (~eoe & 16'h5A5A)), "pin level");
        axi_write(8'h50, 32'h0000FFFC, 4'hF);
        axi_write(8'h54, 32'h00000001, 4'hF);
        repeat (3) @(posedge aclk);
        check(indicator_led_a === 1'b1 && indicator_led_b === 1'b0, "led a");
        axi_write(8'h54, 32'h00000002, 4'hF);
        repeat (3) @(posedge aclk);
        check(indicator_led_a === 1'b0 && indicator_led_b === 1'b1, "led b");
        axi_read(8'h58);
        check(q === 32'h00000002, "led pin level");
        stall = 2;
        axi_write(8'h24, 32'h00005AA5, 4'hF);
        check(r === `RESP_OKAY, "stalled write response");
        stall = 2;
        axi_read(8'h24);
        check(q === 32'h00005AA5 && r === `RESP_OKAY, "stalled read back");
        axi_write(8'h60, 32'h0000FFF3, 4'hF);
        serial_out <= 2'b10;
        serial_oe  <= 2'b01;
        axi_write(`OFS_BANK_CONTROL, 32'h1, 4'hF);
        repeat (3) @(posedge aclk);
        check(pad_out[98] === 1'b0 && pad_oe[99:98] === 2'b01, "serial owns pins");
        axi_write(`OFS_BANK_CONTROL, 32'h0, 4'hF);
        repeat (3) @(posedge aclk);
        check(pad_out[99:98] === 2'b11 && pad_oe[99:98] === 2'b11, "gpio regains");
        do_reset(3);
        @(posedge aclk);
        check(pad_oe === 112'h0, "pads released by reset");
        axi_read(8'h00);
        check(q === 32'h0000FFFF, "direction after reset");
        stop_test();
    end
endmodule

`default_nettype wire
